// ===== logic/afecs_pkg.sv
/*
 * afecs_pkg: shared constants and types of the analog-front-end control and
 * sleep register group.
 * Assumes a 10 MHz management-side clock; register port is a plain
 * synchronous read/write strobe port behind the management serial decoder.
 */
package afecs_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [4:0]  ADDR_AFE_CONTROL_ZERO  = 5'h11;
	localparam logic [4:0]  ADDR_AFE_CONTROL_ONE   = 5'h12;
	localparam logic [4:0]  ADDR_AFE_CONTROL_TWO   = 5'h13;
	localparam logic [4:0]  ADDR_AFE_CONTROL_THREE = 5'h14;
	localparam int          NUM_REGS               = 4;
	localparam logic [15:0] REG_RESET              = 16'h0000;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int BIT_SLOW_OSC_PD      = 6;
	localparam int BIT_TRIM_LSB         = 12;
	localparam int BIT_HIGH_THRESH      = 15;
	localparam int BIT_SLOW_OSC_SLEEP   = 0;
	localparam int BIT_SLEEP_METHOD_CPU = 6;
	localparam int BIT_MANUAL_SLEEP     = 5;
	localparam int BIT_SLEEP_ENABLE     = 3;
	localparam int BIT_LONG_DELAY       = 1;
	localparam logic [3:0] TRIM_LARGEST = 4'h8;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int SHORT_DELAY_NS  = 1000;
	localparam int LONG_DELAY_NS   = 100000;
	localparam logic [15:0] SHORT_DELAY_CYC =
		16'((SHORT_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [15:0] LONG_DELAY_CYC =
		16'((LONG_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} afecs_req_t;

	typedef enum logic [2:0] {
		ST_AWAKE      = 3'h0,
		ST_LOSS_COUNT = 3'h1,
		ST_LOST       = 3'h5,
		ST_SLEEP_AUTO = 3'h3,
		ST_SLEEP_MAN  = 3'h4
	} afecs_state_t;

	typedef struct packed {
		afecs_state_t fsm;
		logic [15:0]  cnt;
		logic         sig_det;
		logic [15:0]  rdata;
		logic         rvalid;
	} afecs_core_t;

	typedef struct packed {
		logic [15:0] q;
	} afecs_cell_t;

endpackage : afecs_pkg

// ===== logic/afecs_reg_cell.sv
/*
 * afecs_reg_cell: one 16-bit read-write control register.
 * Assumes write strobe and data are synchronous to i_clock.
 */
`timescale 1ns/10ps
module afecs_reg_cell (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	input  wire logic        i_clock_en,
	// write side
	input  wire logic        i_wr,
	input  wire logic [15:0] i_wdata,
	// stored value
	output logic      [15:0] o_q
);

	afecs_pkg::afecs_cell_t state_ff;
	afecs_pkg::afecs_cell_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		if (i_wr) begin
			nxt_state.q = i_wdata;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_ff.q <= afecs_pkg::REG_RESET;
		end else if (i_clock_en) begin
			state_ff <= nxt_state;
		end
	end

	assign o_q = state_ff.q;

endmodule : afecs_reg_cell

// ===== logic/afecs_top.sv
/*
 * afecs_top: analog-front-end control register group with slow-oscillator
 * substitution, transmit level trim, diagnostic threshold and ultra-deep
 * sleep control.
 * Assumes the management frame decoder presents one-cycle read and write
 * strobes synchronous to i_clock; cable energy and power-down are
 * synchronous levels.
 */
`timescale 1ns/10ps
module afecs_top (
	// clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_reset,
	input  wire logic                  i_clock_en,
	// register port
	input  wire afecs_pkg::afecs_req_t i_reg_req,
	output logic                [15:0] o_reg_rdata,
	output logic                       o_reg_rvalid,
	// line status
	input  wire logic                  i_cable_energy,
	input  wire logic                  i_power_down,
	// analog controls
	output logic                       o_slow_clk_sel,
	output logic                 [3:0] o_fast_tx_level_trim,
	output logic                 [3:0] o_fast_tx_level_rank,
	output logic                       o_high_thresh_en,
	// sleep status
	output logic                       o_cable_energy_indicator,
	output logic                       o_ultra_deep_sleep
);

	// ---------------------------------------------------------------
	// register cells
	// ---------------------------------------------------------------
	localparam logic [4:0] REG_ADDR [afecs_pkg::NUM_REGS] = '{
		afecs_pkg::ADDR_AFE_CONTROL_ZERO,
		afecs_pkg::ADDR_AFE_CONTROL_ONE,
		afecs_pkg::ADDR_AFE_CONTROL_TWO,
		afecs_pkg::ADDR_AFE_CONTROL_THREE
	};

	logic [15:0]                    reg_q [afecs_pkg::NUM_REGS];
	logic [afecs_pkg::NUM_REGS-1:0] wr_sel;

	// one write strobe per register; unmapped addresses select none
	always_comb begin
		for (int i = 0; i < afecs_pkg::NUM_REGS; i++) begin
			wr_sel[i] = i_reg_req.wr && (i_reg_req.addr == REG_ADDR[i]);
		end
	end

	genvar g;
	generate
		for (g = 0; g < afecs_pkg::NUM_REGS; g++) begin : g_regs
			afecs_reg_cell u_cell (
				.i_clock    (i_clock),
				.i_reset    (i_reset),
				.i_clock_en (i_clock_en),
				.i_wr       (wr_sel[g]),
				.i_wdata    (i_reg_req.wdata),
				.o_q        (reg_q[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// field decode
	// ---------------------------------------------------------------
	logic        slow_osc_pd;
	logic        slow_osc_sleep;
	logic        method_cpu;
	logic        manual_sleep;
	logic        sleep_en;
	logic        long_delay;
	logic [15:0] delay_lim;

	assign slow_osc_pd    = reg_q[0][afecs_pkg::BIT_SLOW_OSC_PD];
	assign slow_osc_sleep = reg_q[2][afecs_pkg::BIT_SLOW_OSC_SLEEP];
	assign method_cpu     = reg_q[3][afecs_pkg::BIT_SLEEP_METHOD_CPU];
	assign manual_sleep   = reg_q[3][afecs_pkg::BIT_MANUAL_SLEEP];
	assign sleep_en       = reg_q[3][afecs_pkg::BIT_SLEEP_ENABLE];
	assign long_delay     = reg_q[3][afecs_pkg::BIT_LONG_DELAY];
	assign delay_lim      = long_delay ? afecs_pkg::LONG_DELAY_CYC
	                                   : afecs_pkg::SHORT_DELAY_CYC;

	// ---------------------------------------------------------------
	// core state
	// ---------------------------------------------------------------
	afecs_pkg::afecs_core_t state_ff;
	afecs_pkg::afecs_core_t nxt_state;
	logic                   manual_go;

	assign manual_go = sleep_en && method_cpu && manual_sleep;

	always_comb begin
		nxt_state        = state_ff;
		nxt_state.rvalid = 1'b0;
		case (state_ff.fsm)
			afecs_pkg::ST_AWAKE: begin
				nxt_state.cnt = 16'h0000;
				if (manual_go) begin
					nxt_state.fsm = afecs_pkg::ST_SLEEP_MAN;
				end else if (sleep_en && !i_cable_energy) begin
					nxt_state.fsm = afecs_pkg::ST_LOSS_COUNT;
				end
			end
			afecs_pkg::ST_LOSS_COUNT: begin
				// counts cycles of continuous cable silence
				nxt_state.cnt = state_ff.cnt + 16'h0001;
				if (manual_go) begin
					nxt_state.fsm = afecs_pkg::ST_SLEEP_MAN;
				end else if (!sleep_en || i_cable_energy) begin
					nxt_state.fsm = afecs_pkg::ST_AWAKE;
				end else if (state_ff.cnt + 16'h0001 >= delay_lim) begin
					nxt_state.fsm = method_cpu ? afecs_pkg::ST_LOST
					                           : afecs_pkg::ST_SLEEP_AUTO;
				end
			end
			afecs_pkg::ST_LOST: begin
				// cpu method: energy gone, waits for manual bit
				if (manual_go) begin
					nxt_state.fsm = afecs_pkg::ST_SLEEP_MAN;
				end else if (!sleep_en || i_cable_energy) begin
					nxt_state.fsm = afecs_pkg::ST_AWAKE;
				end else if (!method_cpu) begin
					nxt_state.fsm = afecs_pkg::ST_SLEEP_AUTO;
				end
			end
			afecs_pkg::ST_SLEEP_AUTO: begin
				if (manual_go) begin
					nxt_state.fsm = afecs_pkg::ST_SLEEP_MAN;
				end else if (!sleep_en || i_cable_energy || method_cpu) begin
					nxt_state.fsm = afecs_pkg::ST_AWAKE;
				end
			end
			afecs_pkg::ST_SLEEP_MAN: begin
				// only the asynchronous reset leaves
				nxt_state.fsm = afecs_pkg::ST_SLEEP_MAN;
			end
			default: begin
				nxt_state.fsm = afecs_pkg::ST_AWAKE;
			end
		endcase

		// indicator follows the next state; forced true while disabled
		case (nxt_state.fsm)
			afecs_pkg::ST_AWAKE,
			afecs_pkg::ST_LOSS_COUNT: begin
				nxt_state.sig_det = 1'b1;
			end
			default: begin
				nxt_state.sig_det = !sleep_en;
			end
		endcase

		// read and write together: read returns the old value
		if (i_reg_req.rd) begin
			nxt_state.rvalid = 1'b1;
			case (i_reg_req.addr)
				afecs_pkg::ADDR_AFE_CONTROL_ZERO:  nxt_state.rdata = reg_q[0];
				afecs_pkg::ADDR_AFE_CONTROL_ONE:   nxt_state.rdata = reg_q[1];
				afecs_pkg::ADDR_AFE_CONTROL_TWO:   nxt_state.rdata = reg_q[2];
				afecs_pkg::ADDR_AFE_CONTROL_THREE: nxt_state.rdata = reg_q[3];
				default:                           nxt_state.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_ff.fsm     <= afecs_pkg::ST_AWAKE;
			state_ff.cnt     <= 16'h0000;
			state_ff.sig_det <= 1'b1;
			state_ff.rdata   <= 16'h0000;
			state_ff.rvalid  <= 1'b0;
		end else if (i_clock_en) begin
			state_ff <= nxt_state;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	logic asleep;

	always_comb begin
		case (state_ff.fsm)
			afecs_pkg::ST_SLEEP_AUTO,
			afecs_pkg::ST_SLEEP_MAN: begin
				asleep = 1'b1;
			end
			default: begin
				asleep = 1'b0;
			end
		endcase
	end

	assign o_ultra_deep_sleep = asleep;
	// select only; the clock mux sits outside
	assign o_slow_clk_sel = (slow_osc_pd && i_power_down) ||
	                        (slow_osc_sleep && asleep);
	assign o_fast_tx_level_trim = reg_q[1][afecs_pkg::BIT_TRIM_LSB +: 4];
	// rank 0 is the largest level, 15 the smallest
	assign o_fast_tx_level_rank = o_fast_tx_level_trim ^ afecs_pkg::TRIM_LARGEST;
	assign o_high_thresh_en = reg_q[2][afecs_pkg::BIT_HIGH_THRESH];
	assign o_cable_energy_indicator = state_ff.sig_det;
	assign o_reg_rdata  = state_ff.rdata;
	assign o_reg_rvalid = state_ff.rvalid;

endmodule : afecs_top

// ===== verif/afecs_chk_sva.sv
/* afecs_chk: port-level assertions for the control and sleep register group.
   assumes a bind onto afecs_top, one clock domain, async active-high reset. */
`timescale 1ns/10ps
module afecs_chk (
	// clock and reset
	input wire logic                  i_clock,
	input wire logic                  i_reset,
	input wire logic                  i_clock_en,
	// watched ports
	input wire afecs_pkg::afecs_req_t i_reg_req,
	input wire logic                  o_reg_rvalid,
	input wire logic                  i_power_down,
	input wire logic                  o_slow_clk_sel,
	input wire logic            [3:0] o_fast_tx_level_trim,
	input wire logic            [3:0] o_fast_tx_level_rank,
	input wire logic                  o_high_thresh_en,
	input wire logic                  o_cable_energy_indicator,
	input wire logic                  o_ultra_deep_sleep
);
	logic rd_go, wr_one, wr_two;
	assign rd_go  = i_clock_en & i_reg_req.rd;
	assign wr_one = i_clock_en & i_reg_req.wr & (i_reg_req.addr == 5'h12);
	assign wr_two = i_clock_en & i_reg_req.wr & (i_reg_req.addr == 5'h13);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_rank; o_fast_tx_level_rank == (o_fast_tx_level_trim ^ 4'h8); endproperty
	a_rank: assert property (p_rank) else $error("rank not trim order");
	property p_trim_wr; wr_one |=> o_fast_tx_level_trim == $past(i_reg_req.wdata[15:12]); endproperty
	a_trim_wr: assert property (p_trim_wr) else $error("trim not written");
	property p_trim_hold; !wr_one |=> $stable(o_fast_tx_level_trim); endproperty
	a_trim_hold: assert property (p_trim_hold) else $error("trim changed");
	property p_thr_wr; wr_two |=> o_high_thresh_en == $past(i_reg_req.wdata[15]); endproperty
	a_thr_wr: assert property (p_thr_wr) else $error("threshold not written");
	property p_rvalid;
		rd_go |=> o_reg_rvalid ##1 (!o_reg_rvalid || $past(rd_go) || !$past(i_clock_en));
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_rv_cause; o_reg_rvalid |-> $past(rd_go) || !$past(i_clock_en); endproperty
	a_rv_cause: assert property (p_rv_cause) else $error("spurious read valid");
	property p_slow; o_slow_clk_sel |-> i_power_down || o_ultra_deep_sleep; endproperty
	a_slow: assert property (p_slow) else $error("slow clock out of place");
	property p_sleep_ind; o_ultra_deep_sleep |-> !o_cable_energy_indicator; endproperty
	a_sleep_ind: assert property (p_sleep_ind) else $error("asleep with energy flag");
endmodule : afecs_chk
bind afecs_top afecs_chk u_chk (.i_clock, .i_reset, .i_clock_en, .i_reg_req, .o_reg_rvalid,
	.i_power_down, .o_slow_clk_sel, .o_fast_tx_level_trim, .o_fast_tx_level_rank,
	.o_high_thresh_en, .o_cable_energy_indicator, .o_ultra_deep_sleep);

// ===== verif/afecs_mgmt.sv
/* afecs_mgmt: management controller model issuing one-cycle register strobes.
   assumes a shared clock and a read answer registered on the taken edge itself. */
`timescale 1ns/10ps
module afecs_mgmt (
	// clock
	input  wire logic                  i_clock,
	// register port
	output afecs_pkg::afecs_req_t      o_req,
	input  wire logic           [15:0] i_rdata,
	input  wire logic                  i_rvalid
);
	initial o_req = '0;
	task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		@(posedge i_clock);
		o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge i_clock);
		// released strobes drop to 0; address and data lines show the inverse of the last value
		o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1;
		ok = w | i_rvalid;
		q = i_rdata;
	endtask : xfer
endmodule : afecs_mgmt

// ===== verif/afe_control_sleep_registers_bench.sv
/* afe_control_sleep_registers_bench: register and sleep scenarios for afecs_top.
   assumes afecs_mgmt drives the register port and afecs_chk is bound. */
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %0t got %h want %h", $time, (g), (e)); end end
module afe_control_sleep_registers_bench;
	logic                  i_clock        = 1'b0;
	logic                  i_reset        = 1'b1;
	logic                  i_clock_en     = 1'b1;
	logic                  i_cable_energy = 1'b1;
	logic                  i_power_down   = 1'b0;
	afecs_pkg::afecs_req_t i_reg_req;
	logic           [15:0] o_reg_rdata;
	logic                  o_reg_rvalid, o_slow_clk_sel, o_high_thresh_en;
	logic                  o_cable_energy_indicator, o_ultra_deep_sleep;
	logic            [3:0] o_fast_tx_level_trim, o_fast_tx_level_rank;
	int                    n_errors = 0, total_checks = 0, n;
	afecs_top dut (.i_clock, .i_reset, .i_clock_en, .i_reg_req, .o_reg_rdata, .o_reg_rvalid,
		.i_cable_energy, .i_power_down, .o_slow_clk_sel, .o_fast_tx_level_trim,
		.o_fast_tx_level_rank, .o_high_thresh_en, .o_cable_energy_indicator, .o_ultra_deep_sleep);
	afecs_mgmt mgmt (.i_clock, .o_req(i_reg_req), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid));
	initial begin
		forever #50 i_clock = ~i_clock;
	end
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic        ok;
		mgmt.xfer(1'b1, a, d, q, ok);
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] q;
		logic        ok;
		mgmt.xfer(1'b0, a, 16'h0000, q, ok);
		`CHK({ok, q}, {1'b1, e})
	endtask : rd
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clock);
		#1;
	endtask : cyc
	task automatic drv(input logic e, input logic p);
		@(posedge i_clock);
		i_cable_energy <= e;
		i_power_down   <= p;
		#1;
	endtask : drv
	task automatic wait_low(input int lim);
		for (n = 0; o_cable_energy_indicator !== 1'b0 && n < lim; n++) cyc(1);
	endtask : wait_low
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		repeat (8) @(posedge i_clock);
		i_reset <= 1'b0;
		cyc(1);
		`CHK({o_fast_tx_level_trim, o_fast_tx_level_rank}, 8'h08)
		`CHK({o_high_thresh_en, o_cable_energy_indicator, o_ultra_deep_sleep, o_slow_clk_sel}, 4'h4)
		for (int i = 0; i < 4; i++) rd(5'h11 + 5'(i), 16'h0000);
		wr(5'h15, 16'hFFFF);
		rd(5'h15, 16'h0000);
		wr(5'h11, 16'hFFBF);
		rd(5'h11, 16'hFFBF);
		for (int c = 0; c < 16; c++) begin
			wr(5'h12, {4'(c), 12'hA5C});
			`CHK({o_fast_tx_level_trim, o_fast_tx_level_rank}, {4'(c), 4'(c) ^ 4'h8})
			rd(5'h12, {4'(c), 12'hA5C});
		end
		// frozen clock enable: a write must not land
		@(posedge i_clock);
		i_clock_en <= 1'b0;
		wr(5'h12, 16'h3000);
		`CHK(o_fast_tx_level_trim, 4'hF)
		@(posedge i_clock);
		i_clock_en <= 1'b1;
		wr(5'h13, 16'h8000);
		`CHK(o_high_thresh_en, 1'b1)
		wr(5'h13, 16'h7FFE);
		`CHK(o_high_thresh_en, 1'b0)
		rd(5'h13, 16'h7FFE);
		wr(5'h11, 16'h0040);
		drv(1'b1, 1'b1);
		`CHK(o_slow_clk_sel, 1'b1)
		wr(5'h11, 16'h0000);
		`CHK(o_slow_clk_sel, 1'b0)
		drv(1'b0, 1'b0);
		cyc(30);
		`CHK({o_cable_energy_indicator, o_ultra_deep_sleep}, 2'b10)
		drv(1'b1, 1'b0);
		wr(5'h14, 16'h0008);
		drv(1'b0, 1'b0);
		wait_low(30);
		`CHK(n inside {[9:12]}, 1'b1)
		`CHK(o_ultra_deep_sleep, 1'b1)
		wr(5'h13, 16'h0001);
		`CHK(o_slow_clk_sel, 1'b1)
		drv(1'b1, 1'b0);
		cyc(1);
		`CHK({o_cable_energy_indicator, o_ultra_deep_sleep, o_slow_clk_sel}, 3'b100)
		wr(5'h14, 16'h000A);
		drv(1'b0, 1'b0);
		wait_low(1100);
		`CHK(n inside {[995:1005]}, 1'b1)
		drv(1'b1, 1'b0);
		wr(5'h14, 16'h0048);
		drv(1'b0, 1'b0);
		wait_low(30);
		cyc(20);
		`CHK({o_cable_energy_indicator, o_ultra_deep_sleep}, 2'b00)
		drv(1'b1, 1'b0);
		wr(5'h14, 16'h0068);
		cyc(1);
		`CHK({o_ultra_deep_sleep, o_slow_clk_sel}, 2'b11)
		drv(1'b0, 1'b0);
		drv(1'b1, 1'b0);
		wr(5'h14, 16'h0008);
		cyc(3);
		`CHK(o_ultra_deep_sleep, 1'b1)
		rd(5'h14, 16'h0008);
		@(posedge i_clock);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_reset <= 1'b0;
		cyc(1);
		`CHK(o_ultra_deep_sleep, 1'b0)
		rd(5'h14, 16'h0000);
		test_done();
	end
endmodule : afe_control_sleep_registers_bench
